// *** core/arx_pkg.sv ***
/*
  Package for the asynchronous receive recovery block: register map,
  field positions, reset values, frame sizes and sampling constants.
  Assumes a 32-bit AHB-Lite slave with word-aligned registers.
*/
package arx_pkg;

  // Register byte offsets
  localparam logic [7:0] ARX_CTRL_OFS   = 8'h00;
  localparam logic [7:0] ARX_DIV_OFS    = 8'h04;
  localparam logic [7:0] ARX_STATUS_OFS = 8'h08;
  localparam logic [7:0] ARX_DATA_OFS   = 8'h0c;

  // Control field positions
  localparam int ARX_CTRL_RXEN_BIT = 0;
  localparam int ARX_CTRL_DSS_BIT  = 1;
  localparam int ARX_CTRL_MDF_BIT  = 2;
  localparam int ARX_CTRL_EXT_BIT  = 3;
  localparam int ARX_CTRL_CSZ_LSB  = 4;
  localparam int ARX_CTRL_CSZ_W    = 3;
  localparam int ARX_CTRL_PEN_BIT  = 7;
  localparam int ARX_CTRL_PODD_BIT = 8;

  // Status field positions
  localparam int ARX_ST_VALID_BIT = 0;
  localparam int ARX_ST_FE_BIT    = 1;
  localparam int ARX_ST_PE_BIT    = 2;
  localparam int ARX_ST_OVR_BIT   = 3;
  localparam int ARX_ST_NINTH_BIT = 4;
  localparam int ARX_ST_BUSY_BIT  = 5;

  // Reset values
  localparam logic [8:0]  ARX_CTRL_RST = 9'h000;
  localparam logic [15:0] ARX_DIV_RST  = 16'h0000;

  // Char size codes: 0..3 = 5..8 bits, 7 = 9 bits
  localparam logic [2:0] ARX_CSZ_NINE = 3'h7;

  // Sampling: samples per bit and first centre sample (vote uses N, N+1, N+2)
  localparam logic [3:0] ARX_SPB_NORM_M1 = 4'hf;
  localparam logic [3:0] ARX_SPB_DBL_M1  = 4'h7;
  localparam logic [3:0] ARX_VOTE_NORM   = 4'h8;
  localparam logic [3:0] ARX_VOTE_DBL    = 4'h4;

  // Receiver states
  typedef enum logic [1:0] {
    ARX_IDLE,
    ARX_START,
    ARX_BITS
  } arx_state_t;

endpackage : arx_pkg

// *** core/arx_rx.sv ***
/*
  Asynchronous serial receiver with start-bit qualification, majority
  bit recovery, frame error detection and multidrop address filtering,
  reached over AHB-Lite. Assumes a single 10 MHz clock and a receive
  line asynchronous to it. One-entry receive holding register.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - Sample at 16x baud, or 8x when double speed is selected.
// - Idle: wait for high-to-low edge; first low sample is sample one.
// - Vote start on samples 8-10 (or 4-6); two highs reject it.
// - Rejected start returns to edge search, no data recovery.
// - Bit timing realigns on every accepted start bit.
// - Per-bit sample counter has 16 states, or 8 in double speed.
// - Each data and parity bit is majority of three centre samples.
// - Recover up to the first stop bit; further stop bits ignored.
// - First stop bit voted too; zero sets the frame error flag.
// - Next start edge accepted right after last stop voting sample.
// - Multidrop filter only in standard mode, not extended mode.
// - Filter on: non-address frames are neither stored nor signalled.
// - Transmit path unaffected by the filter setting.
// - Five to eight data bits: first stop bit is the frame type.
// - Nine data bits: ninth data bit is the frame type.
// - Frame type one means address, zero means data.
// - Address frames under filter are stored and flagged normally.
// - Filter off: all frames accepted and stored normally.
// - Each side keeps baud error within half the total tolerance.
module arx_rx
  import arx_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        RXD,
  output logic             RX_VALID
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic        ap_wr_q,  ap_wr_d;
  logic        ap_rd_q,  ap_rd_d;
  logic [7:0]  ap_addr_q, ap_addr_d;
  logic [8:0]  ctrl_q,   ctrl_d;
  logic [15:0] div_q,    div_d;
  logic [31:0] rdata;
  logic        data_read;
  logic        take;

  assign take      = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  always_comb begin
    ap_wr_d   = take && HWRITE;
    ap_rd_d   = take && !HWRITE;
    ap_addr_d = take ? HADDR[7:0] : ap_addr_q;
    ctrl_d    = ctrl_q;
    div_d     = div_q;
    if (ap_wr_q && ap_addr_q == ARX_CTRL_OFS) begin
      ctrl_d = HWDATA[8:0];
    end
    if (ap_wr_q && ap_addr_q == ARX_DIV_OFS) begin
      div_d = HWDATA[15:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      ctrl_q    <= ARX_CTRL_RST;
      div_q     <= ARX_DIV_RST;
    end else begin
      ap_wr_q   <= ap_wr_d;
      ap_rd_q   <= ap_rd_d;
      ap_addr_q <= ap_addr_d;
      ctrl_q    <= ctrl_d;
      div_q     <= div_d;
    end
  end

  logic       rx_en;
  logic       dbl;
  logic       ext_mode;
  logic       filt_on;
  logic [2:0] csz;
  logic       par_en;
  logic       par_odd;

  assign rx_en    = ctrl_q[ARX_CTRL_RXEN_BIT];
  assign dbl      = ctrl_q[ARX_CTRL_DSS_BIT];
  assign ext_mode = ctrl_q[ARX_CTRL_EXT_BIT];
  assign filt_on  = ctrl_q[ARX_CTRL_MDF_BIT] && !ext_mode;
  assign csz      = ctrl_q[ARX_CTRL_CSZ_LSB +: ARX_CTRL_CSZ_W];
  assign par_en   = ctrl_q[ARX_CTRL_PEN_BIT];
  assign par_odd  = ctrl_q[ARX_CTRL_PODD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser and sample tick

  logic        sync1_q, sync2_q, prev_q;
  logic        sync1_d, sync2_d, prev_d;
  logic [15:0] bdiv_q,  bdiv_d;
  logic        tick;

  // Only sync2 is read downstream; sync1 feeds nothing else
  // Line is kept as seen at the last tick, so a fall between ticks is not lost
  always_comb begin
    sync1_d = RXD;
    sync2_d = sync1_q;
    prev_d  = tick ? sync2_q : prev_q;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  // Sample period is divisor plus one clocks; 0 samples every clock
  // Rate error is left to the clock and divisor chosen by software
  always_comb begin
    tick   = (bdiv_q == 16'h0000);
    bdiv_d = tick ? div_q : bdiv_q - 16'h0001;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      bdiv_q <= 16'h0000;
    end else begin
      bdiv_q <= bdiv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame recovery

  arx_state_t  st_q,    st_d;
  logic [3:0]  nbit_q,  nbit_d;
  logic [8:0]  shf_q,   shf_d;
  logic        parv_q,  parv_d;
  logic [3:0]  ndata;
  logic [3:0]  nframe;
  logic        restart;
  logic        vote_done;
  logic        vote_val;
  logic        bit_end;
  logic        frame_done;
  logic        stop_val;
  logic        fall;

  assign fall   = prev_q && !sync2_q;
  assign ndata  = (csz == ARX_CSZ_NINE) ? 4'd9 : {2'b00, csz[1:0]} + 4'd5;
  assign nframe = ndata + {3'b000, par_en};

  arx_voter u_voter (
    .clk       (CLK),
    .rst       (RST),
    .restart   (restart),
    .tick      (tick),
    .dbl       (dbl),
    .line      (sync2_q),
    .vote_done (vote_done),
    .vote_val  (vote_val),
    .bit_end   (bit_end)
  );

  always_comb begin
    st_d       = st_q;
    nbit_d     = nbit_q;
    shf_d      = shf_q;
    parv_d     = parv_q;
    restart    = 1'b0;
    frame_done = 1'b0;
    stop_val   = vote_val;
    unique case (st_q)
      ARX_IDLE: begin
        if (rx_en && fall && tick) begin
          restart = 1'b1;
          st_d    = ARX_START;
        end
      end
      ARX_START: begin
        if (vote_done) begin
          if (vote_val) begin
            st_d = ARX_IDLE;
          end else begin
            nbit_d = 4'd0;
            parv_d = 1'b0;
          end
        end
        if (bit_end) begin
          st_d = ARX_BITS;
        end
      end
      ARX_BITS: begin
        if (vote_done) begin
          if (nbit_q < ndata) begin
            shf_d = {vote_val, shf_q[8:1]};
          end else if (nbit_q < nframe) begin
            parv_d = vote_val;
          end else begin
            frame_done = 1'b1;
            st_d       = ARX_IDLE;
          end
          nbit_d = nbit_q + 4'd1;
        end
      end
      default: st_d = ARX_IDLE;
    endcase
    if (!rx_en) begin
      st_d = ARX_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q   <= ARX_IDLE;
      nbit_q <= 4'd0;
      shf_q  <= 9'h000;
      parv_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      nbit_q <= nbit_d;
      shf_q  <= shf_d;
      parv_q <= parv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive holding register and multidrop filter

  logic [8:0] data_al;
  logic       ftype;
  logic       accept;
  logic       par_err;
  logic       hold_v_q,  hold_v_d;
  logic [8:0] hold_q,    hold_d;
  logic       fe_q,      fe_d;
  logic       pe_q,      pe_d;
  logic       ovr_q,     ovr_d;

  // Shifted in LSB first; right-justify by character size
  assign data_al = shf_q >> (4'd9 - ndata);
  assign ftype   = (ndata == 4'd9) ? data_al[8] : stop_val;
  // Address when the type bit is one
  assign accept  = frame_done && (!filt_on || ftype);
  assign par_err = par_en && ((^data_al) ^ parv_q ^ par_odd);
  assign data_read = ap_rd_q && ap_addr_q == ARX_DATA_OFS;

  always_comb begin
    hold_v_d = hold_v_q;
    hold_d   = hold_q;
    fe_d     = fe_q;
    pe_d     = pe_q;
    ovr_d    = ovr_q;
    if (data_read) begin
      hold_v_d = 1'b0;
      ovr_d    = 1'b0;
    end
    // A frame landing with the read wins over the clear
    if (accept) begin
      if (hold_v_q && !data_read) begin
        ovr_d = 1'b1;
      end else begin
        hold_v_d = 1'b1;
        hold_d   = data_al;
        fe_d     = !stop_val;
        pe_d     = par_err;
      end
    end
    if (!rx_en) begin
      hold_v_d = 1'b0;
      ovr_d    = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_v_q <= 1'b0;
      hold_q   <= 9'h000;
      fe_q     <= 1'b0;
      pe_q     <= 1'b0;
      ovr_q    <= 1'b0;
    end else begin
      hold_v_q <= hold_v_d;
      hold_q   <= hold_d;
      fe_q     <= fe_d;
      pe_q     <= pe_d;
      ovr_q    <= ovr_d;
    end
  end

  assign RX_VALID = hold_v_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; no transmit path here, so the filter cannot touch one

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (ap_addr_q)
      ARX_CTRL_OFS: rdata = {23'h000000, ctrl_q};
      ARX_DIV_OFS:  rdata = {16'h0000, div_q};
      ARX_STATUS_OFS: begin
        rdata[ARX_ST_VALID_BIT] = hold_v_q;
        rdata[ARX_ST_FE_BIT]    = fe_q;
        rdata[ARX_ST_PE_BIT]    = pe_q;
        rdata[ARX_ST_OVR_BIT]   = ovr_q;
        rdata[ARX_ST_NINTH_BIT] = hold_q[8];
        rdata[ARX_ST_BUSY_BIT]  = (st_q != ARX_IDLE);
      end
      ARX_DATA_OFS: rdata = {23'h000000, hold_q};
      default:      rdata = 32'h0000_0000;
    endcase
    HRDATA = ap_rd_q ? rdata : 32'h0000_0000;
  end

endmodule : arx_rx

// *** core/arx_voter.sv ***
/*
  Sample counter and three-sample majority voter for one serial bit.
  Assumes a one-cycle sample tick and a synchronised receive line.
*/
`timescale 1ns/100ps
module arx_voter
  import arx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       restart,
  input  wire logic       tick,
  input  wire logic       dbl,
  input  wire logic       line,
  output logic            vote_done,
  output logic            vote_val,
  output logic            bit_end
);

  logic [3:0] cnt_q,  cnt_d;
  logic [1:0] ones_q, ones_d;
  logic [3:0] last;
  logic [3:0] first;

  always_comb begin
    last      = dbl ? ARX_SPB_DBL_M1 : ARX_SPB_NORM_M1;
    first     = dbl ? ARX_VOTE_DBL   : ARX_VOTE_NORM;
    cnt_d     = cnt_q;
    ones_d    = ones_q;
    vote_done = 1'b0;
    bit_end   = 1'b0;
    if (restart) begin
      // Restart with sample 1 already taken
      cnt_d  = 4'h1;
      ones_d = 2'h0;
    end else if (tick) begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_d >= first && cnt_d <= first + 4'h2 && line && ones_q != 2'h3) begin
        ones_d = ones_q + 2'h1;
      end
      if (cnt_d == first + 4'h2) begin
        vote_done = 1'b1;
      end
      if (cnt_q == last) begin
        cnt_d   = 4'h0;
        ones_d  = 2'h0;
        bit_end = 1'b1;
      end
    end
    vote_val = (ones_d >= 2'h2);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= 4'h0;
      ones_q <= 2'h0;
    end else begin
      cnt_q  <= cnt_d;
      ones_q <= ones_d;
    end
  end

endmodule : arx_voter

// *** sim/arx_far_tx.sv ***
/* Remote serial transmitter model driving the receive line.
   Assumes the bench sets samples per bit; clocks per sample stays at 2. */
`timescale 1ns/100ps
module arx_far_tx (
  output logic rxd
);
  int spb = 16;
  int cpt = 2;
  initial rxd = 1'b1;
  ////////////////////////////////////////
  // Bit time is an exact multiple of the sample time, so no rate error
  task automatic send(input logic [8:0] d, input int nb, input logic sv, input int ss);
    rxd <= 1'b0;
    #(100 * spb * cpt);
    for (int i = 0; i < nb; i++) begin
      // LSB first, ninth bit is the frame type, or the parity bit after eight data bits
      rxd <= d[i];
      #(100 * spb * cpt);
    end
    rxd <= sv;
    #(100 * ss * cpt);
    // Line high after a typed stop acts as second stop
    rxd <= 1'b1;
  endtask : send
  task automatic spike(input int s);
    rxd <= 1'b0;
    #(100 * s * cpt);
    rxd <= 1'b1;
    #(100 * spb * cpt * 2);
  endtask : spike
endmodule : arx_far_tx

// *** sim/arx_rx_properties.sv ***
/* Checker for arx_rx, watching its top ports only.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/100ps
module arx_rx_checker
  import arx_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        RXD,
  input wire logic        RX_VALID
);
  logic        acc_q, acc_d, rd_q, rd_d;
  logic [31:0] adr_q, adr_d;
  logic [7:0]  age_q, age_d;
  always_comb begin
    acc_d = HSEL & HREADY & HTRANS[1];
    rd_d  = acc_d & ~HWRITE;
    adr_d = HADDR;
    age_d = (age_q == 8'hff) ? age_q : age_q + 8'h01;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      acc_q <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 32'h0;
      age_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
      rd_q  <= rd_d;
      adr_q <= adr_d;
      age_q <= age_d;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_ready; HREADYOUT == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_okay; HRESP == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_rdata_idle; !rd_q |-> HRDATA == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  property p_unmapped; rd_q && adr_q > 32'h0c |-> HRDATA == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_valid;
    rd_q && adr_q == {24'h0, ARX_STATUS_OFS} |-> HRDATA[ARX_ST_VALID_BIT] == RX_VALID;
  endproperty
  a_status_valid: assert property (p_status_valid) else $error("status valid bit");
  property p_early; $rose(RX_VALID) |-> age_q >= 8'd50; endproperty
  a_early: assert property (p_early) else $error("frame stored too soon");
  property p_hold; RX_VALID && !acc_q && !$past(acc_q) |=> RX_VALID; endproperty
  a_hold: assert property (p_hold) else $error("valid dropped unprompted");
  property p_fall; $fell(RX_VALID) |-> $past(acc_q) || $past(acc_q, 2); endproperty
  a_fall: assert property (p_fall) else $error("valid fell without access");
endmodule : arx_rx_checker

bind arx_rx arx_rx_checker chk_u (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
  .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .RXD, .RX_VALID);

// *** sim/arx_rx_tb_top.sv ***
/* Bench for arx_rx: AHB-Lite master tasks, far-end transmitter, scenarios.
   Assumes the checker binds itself and DIV is set to 1. */
`timescale 1ns/100ps
module arx_rx_tb_top;
  import arx_pkg::*;
  logic        CLK, RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, RXD, RX_VALID;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, r;
  int          fail_count, samples_checked;
  assign HREADY = HREADYOUT;
  arx_rx dut_u (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
    .HRDATA, .HREADYOUT, .HRESP, .RXD, .RX_VALID);
  arx_far_tx far_u (.rxd(RXD));
  ////////////////////////////////////////
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : ck
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    r = HRDATA;
    @(posedge CLK);
  endtask : bus
  task automatic cfg(input logic [31:0] c, input int s);
    bus(1'b1, ARX_CTRL_OFS, c);
    far_u.spb = s;
  endtask : cfg
  task automatic tx(input logic [8:0] d, input int nb, input logic sv, input int ss);
    @(posedge CLK);
    far_u.send(d, nb, sv, ss);
  endtask : tx
  task automatic got(input logic [8:0] d, input logic [4:0] st);
    int n;
    n = 0;
    while (RX_VALID !== 1'b1 && n < 3000) begin
      @(negedge CLK);
      n++;
    end
    ck(RX_VALID, 1);
    bus(1'b0, ARX_STATUS_OFS, 0);
    ck(r[4:0], st | 5'h01);
    bus(1'b0, ARX_DATA_OFS, 0);
    ck(r[8:0], d);
    @(negedge CLK);
    ck(RX_VALID, 0);
  endtask : got
  task automatic none();
    repeat (40) @(negedge CLK);
    ck(RX_VALID, 0);
  endtask : none
  ////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, ARX_CTRL_OFS, 0);
    ck(r, 0);
    bus(1'b1, 32'h10, 32'hffffffff);
    bus(1'b0, 32'h10, 0);
    ck(r, 0);
    bus(1'b1, ARX_DIV_OFS, 1);
    bus(1'b0, ARX_DIV_OFS, 0);
    ck(r, 1);
  endtask : t_regs
  task automatic t_norm();
    cfg(32'h31, 16);
    tx(9'h0a5, 8, 1'b1, 16);
    got(9'h0a5, 5'h00);
    tx(9'h03c, 8, 1'b0, 16);
    got(9'h03c, 5'h02);
    @(posedge CLK);
    far_u.spike(8);
    none();
    tx(9'h05a, 8, 1'b1, 16);
    got(9'h05a, 5'h00);
    cfg(32'h1b1, 16);
    tx(9'h1a5, 9, 1'b1, 16);
    got(9'h0a5, 5'h00);
    tx(9'h0a5, 9, 1'b1, 16);
    got(9'h0a5, 5'h04);
  endtask : t_norm
  task automatic t_dbl();
    cfg(32'h33, 8);
    fork
      begin
        tx(9'h0c3, 8, 1'b1, 7);
        far_u.send(9'h03e, 8, 1'b1, 8);
      end
      begin
        got(9'h0c3, 5'h00);
        got(9'h03e, 5'h00);
      end
    join
  endtask : t_dbl
  task automatic t_multi();
    cfg(32'h75, 16);
    tx(9'h011, 9, 1'b1, 16);
    none();
    tx(9'h1a2, 9, 1'b1, 16);
    got(9'h1a2, 5'h10);
    cfg(32'h71, 16);
    tx(9'h044, 9, 1'b1, 16);
    got(9'h044, 5'h00);
    cfg(32'h05, 16);
    tx(9'h015, 5, 1'b0, 16);
    none();
    tx(9'h00a, 5, 1'b1, 16);
    got(9'h00a, 5'h00);
    cfg(32'h0d, 16);
    tx(9'h015, 5, 1'b0, 16);
    got(9'h015, 5'h02);
  endtask : t_multi
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // Run needs well under 20000 cycles; the limit leaves twice that
  initial begin
    #4000000;
    fail_count++;
    stop_test();
  end
  initial begin
    RST = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_norm();
    t_dbl();
    t_multi();
    stop_test();
  end
endmodule : arx_rx_tb_top
